// ---- common/rpmc_map.svh ----
// Register offsets, field positions, reset values, vectors and cycle counts of the reset and power mode controller
`ifndef RPMC_MAP_SVH
`define RPMC_MAP_SVH

// Byte offsets on the register bus
`define RPMC_OFS_FCFG 8'h00
`define RPMC_OFS_POWER_CONTROL_REG 8'h04
`define RPMC_OFS_INTEN 8'h08
`define RPMC_OFS_PRIO 8'h0c
`define RPMC_OFS_STAT 8'h10
`define RPMC_OFS_WATCHDOG_CONTROL_REG 8'h14
`define RPMC_OFS_IEA 8'he8

// Field positions
`define RPMC_FCFG_SWR 1
`define RPMC_WATCHDOG_CONTROL_REG_WATCHDOG_RESET_FLAG 2
`define RPMC_IEA_EBO 3
`define RPMC_POWER_CONTROL_REG_IDL 0
`define RPMC_POWER_CONTROL_REG_PD 1
`define RPMC_INTEN_IT0 8
`define RPMC_INTEN_IT1 9

// Reset values
`define RPMC_INTEN_RST 7'h00
`define RPMC_IT_RST 2'h0
`define RPMC_PRIO_RST 14'h0000

// Program addresses
`define RPMC_VEC_RESET 16'h0000
`define RPMC_VEC_EX0 16'h0003
`define RPMC_VEC_T0 16'h000b
`define RPMC_VEC_EX1 16'h0013
`define RPMC_VEC_T1 16'h001b
`define RPMC_VEC_SER 16'h0023
`define RPMC_VEC_T2 16'h002b
`define RPMC_VEC_BO 16'h004b

// Cycle counts at MCLK
`define RPMC_RST_FILT_CLKS 5'd24
`define RPMC_RST_HOLD_CLKS 5'd24
`define RPMC_PD_WAKE_CLKS 11'd1024

`endif

// ---- common/rpmc_pkg.sv ----
// Types and vector lookup shared by the reset and power mode controller
`include "rpmc_map.svh"
package rpmc_pkg;

   // Sequencer states
   typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_IDLE, ST_PDOWN} rpmc_state_e;

   // Requests in arbitration rank order, bit 0 ranks highest
   typedef struct packed {
      logic t2;
      logic ser;
      logic t1;
      logic ex1;
      logic t0;
      logic bo;
      logic ex0;
   } rpmc_src_s;

   // Two priority bits per source, source i at [2i+1:2i]
   typedef logic [13:0] rpmc_prio_t;

   // Arbitration winner
   typedef struct packed {
      logic valid;
      logic [2:0] idx;
   } rpmc_pick_s;

   // Vector of a source index
   function automatic logic [15:0] vec_of(input logic [2:0] idx);
      case (idx)
         3'h0: return `RPMC_VEC_EX0;
         3'h1: return `RPMC_VEC_BO;
         3'h2: return `RPMC_VEC_T0;
         3'h3: return `RPMC_VEC_EX1;
         3'h4: return `RPMC_VEC_T1;
         3'h5: return `RPMC_VEC_SER;
         default: return `RPMC_VEC_T2;
      endcase
   endfunction : vec_of

endpackage : rpmc_pkg

// ---- design/rpmc_irq_arb.sv ----
// Priority and rank arbiter for the seven interrupt sources
`timescale 1ns/10ps
`default_nettype none
module rpmc_irq_arb
   import rpmc_pkg::*;
(
   // Requests and levels
   input wire rpmc_src_s req,
   input wire rpmc_prio_t prio,
   // Winner
   output rpmc_pick_s pick
);

   logic [6:0] req_v;
   logic [1:0] best;

   assign req_v = req;

   // Highest level wins; strict compare keeps the better rank on a tie
   always_comb begin
      pick = '0;
      best = 2'h0;
      for (int i = 0; i < 7; i++) begin
         if (req_v[i] && (!pick.valid || prio[2*i +: 2] > best)) begin
            pick.valid = 1'b1;
            pick.idx = i[2:0];
            best = prio[2*i +: 2];
         end
      end
   end

endmodule : rpmc_irq_arb
`default_nettype wire

// ---- design/rpmc_top.sv ----
// Reset sequencing, interrupt vectoring and power mode control with an Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
`include "rpmc_map.svh"
module rpmc_top
   import rpmc_pkg::*;
(
   // Clock and power-on reset
   input wire logic MCLK,
   input wire logic RST_N,
   // Avalon-MM slave
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Reset sources
   input wire logic RST_PIN,
   input wire logic BOD_DET,
   input wire logic WDT_EXPIRE,
   // Interrupt pins and peripheral requests
   input wire logic EXT_INT0_N,
   input wire logic EXT_INT1_N,
   input wire logic TMR0_REQ,
   input wire logic TMR1_REQ,
   input wire logic SER_REQ,
   input wire logic SPI_REQ,
   input wire logic TMR2_REQ,
   // CPU side
   input wire logic IRQ_ACK,
   output logic CPU_RST,
   output logic PC_HALT,
   output logic PC_LOAD,
   output logic [15:0] PC_START,
   output logic IRQ_REQ,
   output logic [15:0] IRQ_VECTOR,
   // Clock and pad control
   output logic CLK_STOP,
   output logic STROBE_OVR,
   output logic STROBE_LEVEL,
   output logic STROBE_WEAK,
   output logic PORT_WEAK_PULLUP
);

   rpmc_state_e state_q, state_d;
   rpmc_src_s req;
   rpmc_pick_s pick;
   logic rst_s1, rst_s2;
   logic [4:0] rst_cnt_q, hold_q;
   logic [10:0] wake_cnt_q;
   logic pin_rst, hold_done, wake_done, qual_low;
   logic soft_trig, bo_rst, sys_rst_req, sfr_clr;
   logic wait_q, wr_en, rd_ld, ack_fire;
   logic [31:0] rdata, rdata_q;
   logic swr_q, watchdog_reset_flag_q, ebo_q, idl_q, pd_q, bof_q;
   logic [6:0] inten_q;
   logic [1:0] it_q, ie_q, ext_prev_q, ext_n, ack_ext;
   rpmc_prio_t prio_q;
   logic [2:0] idx_q;
   logic irq_req_q, cpu_rst_q, pc_halt_q, pc_load_q, clk_stop_q;
   logic ovr_q, lvl_q, weak_q;
   logic [15:0] irq_vec_q, pc_start_q;

   // Write strobe for one byte lane of one register
   function automatic logic wr_hit(input logic [7:0] ofs, input logic [1:0] lane);
      return wr_en && (AVS_ADDRESS == ofs) && AVS_BYTEENABLE[lane];
   endfunction : wr_hit

   // Bus timing: a request answers one cycle after it is seen
   assign wr_en = AVS_WRITE && !wait_q;
   assign rd_ld = AVS_READ && wait_q;
   assign ext_n = {EXT_INT1_N, EXT_INT0_N};
   assign ack_fire = IRQ_ACK && irq_req_q;
   assign ack_ext = {ack_fire && (idx_q == 3'h3), ack_fire && (idx_q == 3'h0)};

   // Reset pin synchroniser; only the second stage is looked at
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= RST_PIN;
         rst_s2 <= rst_s1;
      end
   end

   // Consecutive high samples; a glitch restarts the count
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_cnt_q <= 5'h00;
      end else if (!rst_s2) begin
         rst_cnt_q <= 5'h00;
      end else if (rst_cnt_q != `RPMC_RST_FILT_CLKS) begin
         rst_cnt_q <= rst_cnt_q + 5'h01;
      end
   end

   // Reset causes
   assign pin_rst = (rst_cnt_q == `RPMC_RST_FILT_CLKS);
   assign soft_trig = wr_hit(`RPMC_OFS_FCFG, 2'h0) && AVS_WRITEDATA[`RPMC_FCFG_SWR] && !swr_q;
   // Clearing the enable while brown-out persists falls into this same term
   assign bo_rst = BOD_DET && !ebo_q;
   assign sys_rst_req = pin_rst || soft_trig || bo_rst || WDT_EXPIRE;
   assign sfr_clr = sys_rst_req || (state_q == ST_RESET);
   assign hold_done = (hold_q == `RPMC_RST_HOLD_CLKS);

   // Reset stretch so every cause gives the CPU a full reset pulse
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         hold_q <= 5'h00;
      end else if (sys_rst_req) begin
         hold_q <= 5'h00;
      end else if (!hold_done) begin
         hold_q <= hold_q + 5'h01;
      end
   end

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      if (sys_rst_req) begin
         state_d = ST_RESET;
      end else begin
         case (state_q)
            ST_RESET: begin
               if (hold_done) state_d = ST_RUN;
            end
            ST_RUN: begin
               if (pd_q) state_d = ST_PDOWN;
               else if (idl_q) state_d = ST_IDLE;
            end
            ST_IDLE: begin
               if (!idl_q) state_d = ST_RUN;
            end
            ST_PDOWN: begin
               if (!pd_q) state_d = ST_RUN;
            end
            default: state_d = ST_RESET;
         endcase
      end
   end

   // Sequencer state; a gated clock simply freezes it in place
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // Flash configuration trigger bit survives system resets
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         swr_q <= 1'b0;
      end else if (wr_hit(`RPMC_OFS_FCFG, 2'h0)) begin
         swr_q <= AVS_WRITEDATA[`RPMC_FCFG_SWR];
      end
   end

   // Watchdog reset flag; a new expiry beats a clear in the same cycle
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         watchdog_reset_flag_q <= 1'b0;
      end else if (WDT_EXPIRE) begin
         watchdog_reset_flag_q <= 1'b1;
      end else if (wr_hit(`RPMC_OFS_WATCHDOG_CONTROL_REG, 2'h0) && AVS_WRITEDATA[`RPMC_WATCHDOG_CONTROL_REG_WATCHDOG_RESET_FLAG]) begin
         watchdog_reset_flag_q <= 1'b0;
      end
   end

   // Brown-out interrupt enable
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ebo_q <= 1'b0;
      end else if (sfr_clr) begin
         ebo_q <= 1'b0;
      end else if (wr_hit(`RPMC_OFS_IEA, 2'h0)) begin
         ebo_q <= AVS_WRITEDATA[`RPMC_IEA_EBO];
      end
   end

   // Power control; the start of service clears both mode bits
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         idl_q <= 1'b0;
         pd_q <= 1'b0;
      end else if (sfr_clr) begin
         idl_q <= 1'b0;
         pd_q <= 1'b0;
      end else if (wr_hit(`RPMC_OFS_POWER_CONTROL_REG, 2'h0)) begin
         idl_q <= AVS_WRITEDATA[`RPMC_POWER_CONTROL_REG_IDL];
         pd_q <= AVS_WRITEDATA[`RPMC_POWER_CONTROL_REG_PD];
      end else if (ack_fire) begin
         idl_q <= 1'b0;
         pd_q <= 1'b0;
      end
   end

   // Enables, trigger types and priority levels
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         inten_q <= `RPMC_INTEN_RST;
         it_q <= `RPMC_IT_RST;
         prio_q <= `RPMC_PRIO_RST;
      end else if (sfr_clr) begin
         inten_q <= `RPMC_INTEN_RST;
         it_q <= `RPMC_IT_RST;
         prio_q <= `RPMC_PRIO_RST;
      end else begin
         if (wr_hit(`RPMC_OFS_INTEN, 2'h0)) inten_q <= AVS_WRITEDATA[6:0];
         if (wr_hit(`RPMC_OFS_INTEN, 2'h1)) it_q <= AVS_WRITEDATA[`RPMC_INTEN_IT1:`RPMC_INTEN_IT0];
         if (wr_hit(`RPMC_OFS_PRIO, 2'h0)) prio_q[7:0] <= AVS_WRITEDATA[7:0];
         if (wr_hit(`RPMC_OFS_PRIO, 2'h1)) prio_q[13:8] <= AVS_WRITEDATA[13:8];
      end
   end

   // External interrupt flags: level mode follows the pin, edge mode latches a fall
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ie_q <= 2'h0;
         ext_prev_q <= 2'h3;
      end else begin
         ext_prev_q <= ext_n;
         for (int i = 0; i < 2; i++) begin
            if (sfr_clr) ie_q[i] <= 1'b0;
            else if (!it_q[i]) ie_q[i] <= !ext_n[i];
            else if (ext_prev_q[i] && !ext_n[i]) ie_q[i] <= 1'b1;
            else if (ack_ext[i]) ie_q[i] <= 1'b0;
         end
      end
   end

   // Brown-out flag; detection wins over the clear on acknowledge
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         bof_q <= 1'b0;
      end else if (sfr_clr) begin
         bof_q <= 1'b0;
      end else if (BOD_DET && ebo_q) begin
         bof_q <= 1'b1;
      end else if (ack_fire && idx_q == 3'h1) begin
         bof_q <= 1'b0;
      end
   end

   // Enabled level-sensitive external pin held low during power-down
   assign qual_low = (inten_q[0] && !it_q[0] && !EXT_INT0_N) || (inten_q[3] && !it_q[1] && !EXT_INT1_N);
   assign wake_done = (wake_cnt_q == `RPMC_PD_WAKE_CLKS);

   // Wake-up low time; the service request waits for the full count
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         wake_cnt_q <= 11'h000;
      end else if (!pd_q || !qual_low) begin
         wake_cnt_q <= 11'h000;
      end else if (!wake_done) begin
         wake_cnt_q <= wake_cnt_q + 11'h001;
      end
   end

   // Qualified requests; power-down admits only level external interrupts
   always_comb begin
      req = '0;
      req.ex0 = inten_q[0] && ie_q[0];
      req.bo = ebo_q && bof_q;
      req.t0 = inten_q[2] && TMR0_REQ;
      req.ex1 = inten_q[3] && ie_q[1];
      req.t1 = inten_q[4] && TMR1_REQ;
      req.ser = inten_q[5] && (SER_REQ || SPI_REQ);
      req.t2 = inten_q[6] && TMR2_REQ;
      if (pd_q) begin
         req = '0;
         req.ex0 = inten_q[0] && ie_q[0] && !it_q[0] && wake_done;
         req.ex1 = inten_q[3] && ie_q[1] && !it_q[1] && wake_done;
      end
      if (state_q == ST_RESET) req = '0;
   end

   rpmc_irq_arb u_arb (
      .req(req),
      .prio(prio_q),
      .pick(pick)
   );

   // Request and vector to the CPU; dropped for one cycle after each acknowledge
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_req_q <= 1'b0;
         idx_q <= 3'h0;
         irq_vec_q <= `RPMC_VEC_RESET;
      end else begin
         irq_req_q <= pick.valid && !sys_rst_req && !ack_fire;
         idx_q <= pick.idx;
         irq_vec_q <= vec_of(pick.idx);
      end
   end

   // CPU control and pad outputs decoded from the next state; PC_START stays at the reset vector
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cpu_rst_q <= 1'b1;
         pc_halt_q <= 1'b1;
         pc_load_q <= 1'b0;
         pc_start_q <= `RPMC_VEC_RESET;
         clk_stop_q <= 1'b0;
         ovr_q <= 1'b1;
         lvl_q <= 1'b1;
         weak_q <= 1'b1;
      end else begin
         cpu_rst_q <= (state_d == ST_RESET);
         pc_halt_q <= (state_d != ST_RUN);
         pc_load_q <= (state_q == ST_RESET) && (state_d == ST_RUN);
         pc_start_q <= `RPMC_VEC_RESET;
         clk_stop_q <= (state_d == ST_PDOWN) && !qual_low;
         ovr_q <= (state_d != ST_RUN);
         lvl_q <= (state_d != ST_PDOWN);
         weak_q <= (state_d == ST_RESET);
      end
   end

   // Register readback; unmapped offsets read zero
   always_comb begin
      rdata = 32'h00000000;
      case (AVS_ADDRESS)
         `RPMC_OFS_FCFG: rdata[`RPMC_FCFG_SWR] = swr_q;
         `RPMC_OFS_POWER_CONTROL_REG: rdata[1:0] = {pd_q, idl_q};
         `RPMC_OFS_INTEN: rdata[9:0] = {it_q, 1'b0, inten_q};
         `RPMC_OFS_PRIO: rdata[13:0] = prio_q;
         `RPMC_OFS_STAT: rdata[5:0] = {wake_done, bof_q, ie_q, state_q};
         `RPMC_OFS_WATCHDOG_CONTROL_REG: rdata[`RPMC_WATCHDOG_CONTROL_REG_WATCHDOG_RESET_FLAG] = watchdog_reset_flag_q;
         `RPMC_OFS_IEA: rdata[`RPMC_IEA_EBO] = ebo_q;
         default: rdata = 32'h00000000;
      endcase
   end

   // Bus answer: waitrequest drops for exactly one cycle per access
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
         if (rd_ld) rdata_q <= rdata;
      end
   end

   assign AVS_WAITREQUEST = wait_q;
   assign AVS_READDATA = rdata_q;
   assign CPU_RST = cpu_rst_q;
   assign PC_HALT = pc_halt_q;
   assign PC_LOAD = pc_load_q;
   assign PC_START = pc_start_q;
   assign IRQ_REQ = irq_req_q;
   assign IRQ_VECTOR = irq_vec_q;
   assign CLK_STOP = clk_stop_q;
   assign STROBE_OVR = ovr_q;
   assign STROBE_LEVEL = lvl_q;
   assign STROBE_WEAK = weak_q;
   assign PORT_WEAK_PULLUP = weak_q;

   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   sequence s_pin_rise;
      $rose(rst_s2);
   endsequence
   sequence s_soft;
      soft_trig;
   endsequence
   sequence s_ack_idle;
      ack_fire && idl_q && !sfr_clr && !wr_hit(`RPMC_OFS_POWER_CONTROL_REG, 2'h0);
   endsequence

   AST_PIN_FILTER: assert property (s_pin_rise |-> !pin_rst [*8]) else $error("reset pin taken too early");
   AST_PC_START: assert property ($fell(CPU_RST) |-> PC_LOAD && PC_START == 16'h0000) else $error("bad restart");
   AST_RST_STROBE: assert property (CPU_RST |-> STROBE_WEAK && STROBE_LEVEL && PORT_WEAK_PULLUP) else $error("strobes");
   AST_SOFT_RST: assert property (s_soft |=> CPU_RST && swr_q && !ebo_q) else $error("soft reset");
   AST_BO_RST: assert property (BOD_DET && !ebo_q |=> CPU_RST ##1 CPU_RST) else $error("brown-out reset missed");
   AST_BO_VEC: assert property (IRQ_REQ && IRQ_VECTOR == 16'h004b |-> $past(ebo_q)) else $error("brown-out vector");
   AST_IDLE_EXIT: assert property (s_ack_idle |=> !idl_q ##1 !PC_HALT) else $error("idle not left");
   AST_MODE_STROBE: assert property (state_q == ST_PDOWN |-> !STROBE_LEVEL && STROBE_OVR) else $error("pd strobes");
   AST_PD_WAKE: assert property ($rose(IRQ_REQ) && pd_q && $past(pd_q) |-> $past(wake_done))
      else $error("early wake");
   AST_RANK: assert property (req.ex0 && req.t0 && prio_q[1:0] == prio_q[5:4] && !sys_rst_req && !ack_fire
      |=> IRQ_VECTOR != 16'h000b) else $error("rank");

endmodule : rpmc_top
`default_nettype wire

// ---- testbench/rpmc_far_model.sv ----
// Far-side model: reset circuit, external interrupt pins and clock gate
`timescale 1ns/10ps
`default_nettype none
module rpmc_far_model
(
   // Free oscillator and bench commands
   input wire logic free_clk,
   input wire logic gate_off,
   input wire logic rst_go,
   input wire logic [7:0] rst_len,
   input wire logic [1:0] int_go,
   // Pins seen by the block
   output logic mclk,
   output logic rst_pin,
   output logic [1:0] ext_int_n
);
   logic en_q = 1'b1;
   logic [7:0] rst_cnt_q = 8'h00;
   logic [10:0] int_cnt_q [2] = '{11'h000, 11'h000};

   // Gate moves on the falling edge, so no high phase is ever cut short
   always_ff @(negedge free_clk) begin
      en_q <= !gate_off;
   end
   assign mclk = free_clk & en_q;

   // Reset pin high for the asked length; the pin's pull-down gives low otherwise
   always_ff @(posedge free_clk) begin
      if (rst_go)
         rst_cnt_q <= rst_len;
      else if (rst_cnt_q != 8'h00)
         rst_cnt_q <= rst_cnt_q - 8'h01;
   end
   assign rst_pin = (rst_cnt_q != 8'h00);

   // Pins stay low 1100 clocks once asked, beyond the wake-up minimum; pull-ups give high at rest
   always_ff @(posedge free_clk) begin
      for (int i = 0; i < 2; i++) begin
         if (int_go[i])
            int_cnt_q[i] <= 11'h44c;
         else if (int_cnt_q[i] != 11'h000)
            int_cnt_q[i] <= int_cnt_q[i] - 11'h001;
      end
   end
   assign ext_int_n = {int_cnt_q[1] == 11'h000, int_cnt_q[0] == 11'h000};
endmodule : rpmc_far_model
`default_nettype wire

// ---- testbench/rpmc_top_bench.sv ----
// Self-checking bench of the reset and power mode controller
`timescale 1ns/10ps
`default_nettype none
`include "rpmc_map.svh"
module rpmc_top_bench;
   logic free_clk = 1'b0, rst_n = 1'b0, avs_rd = 1'b0, avs_wr = 1'b0, bod = 1'b0, wdt = 1'b0, ack = 1'b0;
   logic gate_off = 1'b0, rst_go = 1'b0;
   logic [7:0] rst_len = 8'h00, addr = 8'h00;
   logic [1:0] int_go = 2'h0;
   logic [4:0] req = 5'h00;
   logic [31:0] wdata = 32'h0, rdata, seed = 32'h4848af26;
   logic [15:0] pc_start, irq_vec;
   logic waitreq, cpu_rst, pc_halt, pc_load, irq_req, clk_stop, s_ovr, s_lvl, s_weak, p_pull;
   wire logic mclk, rst_pin;
   wire logic [1:0] ext_n;
   int miscompares = 0, tests_run = 0;
   logic [31:0] exp_q[$], msk_q[$];
   logic [15:0] vecs [6] = '{`RPMC_VEC_T0, `RPMC_VEC_EX1, `RPMC_VEC_T1, `RPMC_VEC_SER, `RPMC_VEC_SER, `RPMC_VEC_T2};
   int bits [6] = '{2, 3, 4, 5, 5, 6};

   // Oscillator before the external gate
   always #5 free_clk = ~free_clk;

   // Byte lanes fixed to the two lanes the block decodes
   rpmc_top dut (
      .MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(avs_rd), .AVS_WRITE(avs_wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .RST_PIN(rst_pin), .BOD_DET(bod), .WDT_EXPIRE(wdt), .EXT_INT0_N(ext_n[0]), .EXT_INT1_N(ext_n[1]),
      .TMR0_REQ(req[0]), .TMR1_REQ(req[1]), .SER_REQ(req[2]), .SPI_REQ(req[3]), .TMR2_REQ(req[4]),
      .IRQ_ACK(ack), .CPU_RST(cpu_rst), .PC_HALT(pc_halt), .PC_LOAD(pc_load), .PC_START(pc_start),
      .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vec), .CLK_STOP(clk_stop), .STROBE_OVR(s_ovr),
      .STROBE_LEVEL(s_lvl), .STROBE_WEAK(s_weak), .PORT_WEAK_PULLUP(p_pull)
   );

   rpmc_far_model far (
      .free_clk(free_clk), .gate_off(gate_off), .rst_go(rst_go), .rst_len(rst_len), .int_go(int_go),
      .mclk(mclk), .rst_pin(rst_pin), .ext_int_n(ext_n)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   // One bus cycle; entered just after a rising edge, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      if (w)
         avs_wr <= 1'b1;
      else
         avs_rd <= 1'b1;
      do @(posedge mclk); while (waitreq !== 1'b0);
      avs_rd <= 1'b0;
      avs_wr <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic put(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : put

   // The expected read value is noted before the cycle starts
   task automatic get(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask : get

   // Read results are compared against the oldest note as they appear
   always @(posedge mclk) begin
      if (avs_rd === 1'b1 && waitreq === 1'b0 && exp_q.size() > 0)
         chk(rdata & msk_q.pop_front(), exp_q.pop_front());
   end

   function automatic logic sel(input int s);
      case (s)
         0: return pc_load;
         1: return irq_req;
         2: return !clk_stop;
         default: return cpu_rst;
      endcase
   endfunction : sel

   // Bounded wait on a completion signal; running out is itself a mismatch
   task automatic wait_on(input int s, input int lim);
      int n;
      n = 0;
      while (sel(s) !== 1'b1 && n < lim) begin
         @(posedge mclk);
         n++;
      end
      chk(sel(s), 32'h1);
   endtask : wait_on

   task automatic ack_irq;
      ack <= 1'b1;
      @(posedge mclk);
      ack <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : ack_irq

   task automatic note(input string s);
      $display("test %s done", s);
   endtask : note

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   // Winner among equal levels, in fixed rank order
   function automatic logic [15:0] top_vec(input logic [4:0] r);
      if (r[0])
         return `RPMC_VEC_T0;
      if (r[1])
         return `RPMC_VEC_T1;
      if (r[3:2] != 2'h0)
         return `RPMC_VEC_SER;
      return `RPMC_VEC_T2;
   endfunction : top_vec

   initial begin
      logic [4:0] r;
      repeat (8) @(posedge free_clk);
      chk({s_ovr, s_lvl, s_weak, p_pull}, 32'hf);
      rst_n <= 1'b1;
      wait_on(0, 40);
      chk(pc_start, `RPMC_VEC_RESET);
      get(`RPMC_OFS_POWER_CONTROL_REG, 32'h3, 32'h0);
      get(`RPMC_OFS_INTEN, 32'h37f, 32'h0);
      get(`RPMC_OFS_IEA, 32'h8, 32'h0);
      put(8'h40, 32'hffff);
      get(8'h40, 32'hffffffff, 32'h0);
      note("reset_values");
      for (int k = 0; k < 6; k++) begin
         put(`RPMC_OFS_INTEN, 32'h1 << bits[k]);
         if (k == 1)
            int_go <= 2'h2;
         else
            req <= 5'h01 << (k - (k > 1));
         @(posedge mclk);
         int_go <= 2'h0;
         wait_on(1, 10);
         chk(irq_vec, vecs[k]);
         req <= 5'h00;
         ack_irq();
         put(`RPMC_OFS_INTEN, 32'h0);
      end
      note("vectors");
      // Ext1 pin may still be held low, so its enable stays off here
      put(`RPMC_OFS_INTEN, 32'h75);
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         r = (seed[4:0] == 5'h00) ? 5'h10 : seed[4:0];
         req <= r;
         wait_on(1, 10);
         chk(irq_vec, top_vec(r));
         req <= 5'h00;
         ack_irq();
      end
      put(`RPMC_OFS_PRIO, 32'h3020);
      get(`RPMC_OFS_PRIO, 32'h3fff, 32'h3020);
      req <= 5'h11;
      wait_on(1, 10);
      chk(irq_vec, `RPMC_VEC_T2);
      req <= 5'h00;
      ack_irq();
      put(`RPMC_OFS_PRIO, 32'h0);
      note("arbitration");
      put(`RPMC_OFS_INTEN, 32'h4);
      put(`RPMC_OFS_POWER_CONTROL_REG, 32'h1);
      repeat (2) @(posedge mclk);
      chk({pc_halt, s_ovr, s_lvl}, 32'h7);
      get(`RPMC_OFS_POWER_CONTROL_REG, 32'h3, 32'h1);
      req <= 5'h01;
      wait_on(1, 10);
      chk(irq_vec, `RPMC_VEC_T0);
      req <= 5'h00;
      ack_irq();
      get(`RPMC_OFS_POWER_CONTROL_REG, 32'h3, 32'h0);
      chk(pc_halt, 32'h0);
      note("idle");
      put(`RPMC_OFS_INTEN, 32'h1);
      put(`RPMC_OFS_POWER_CONTROL_REG, 32'h2);
      repeat (2) @(posedge mclk);
      chk({clk_stop, s_ovr, s_lvl}, 32'h6);
      int_go <= 2'h1;
      @(posedge mclk);
      int_go <= 2'h0;
      wait_on(2, 6);
      repeat (500) @(posedge mclk);
      chk(irq_req, 32'h0);
      wait_on(1, 700);
      chk(irq_vec, `RPMC_VEC_EX0);
      ack_irq();
      get(`RPMC_OFS_POWER_CONTROL_REG, 32'h3, 32'h0);
      put(`RPMC_OFS_INTEN, 32'h0);
      repeat (700) @(posedge mclk);
      note("power_down");
      wdt <= 1'b1;
      @(posedge mclk);
      wdt <= 1'b0;
      wait_on(3, 5);
      wait_on(0, 40);
      put(`RPMC_OFS_INTEN, 32'h14);
      put(`RPMC_OFS_FCFG, 32'h2);
      wait_on(3, 5);
      wait_on(0, 40);
      chk(pc_start, `RPMC_VEC_RESET);
      get(`RPMC_OFS_FCFG, 32'h2, 32'h2);
      get(`RPMC_OFS_WATCHDOG_CONTROL_REG, 32'h4, 32'h4);
      get(`RPMC_OFS_INTEN, 32'h37f, 32'h0);
      put(`RPMC_OFS_FCFG, 32'h0);
      put(`RPMC_OFS_WATCHDOG_CONTROL_REG, 32'h4);
      get(`RPMC_OFS_WATCHDOG_CONTROL_REG, 32'h4, 32'h0);
      note("soft_reset");
      put(`RPMC_OFS_IEA, 32'h8);
      bod <= 1'b1;
      wait_on(1, 10);
      chk(irq_vec, `RPMC_VEC_BO);
      ack_irq();
      put(`RPMC_OFS_IEA, 32'h0);
      wait_on(3, 5);
      bod <= 1'b0;
      wait_on(0, 40);
      bod <= 1'b1;
      wait_on(3, 5);
      bod <= 1'b0;
      wait_on(0, 40);
      chk(pc_start, `RPMC_VEC_RESET);
      note("brown_out");
      rst_len <= 8'h0a;
      rst_go <= 1'b1;
      @(posedge mclk);
      rst_go <= 1'b0;
      repeat (40) @(posedge mclk);
      chk(cpu_rst, 32'h0);
      rst_len <= 8'h1e;
      rst_go <= 1'b1;
      @(posedge mclk);
      rst_go <= 1'b0;
      wait_on(3, 35);
      chk({s_ovr, s_lvl, s_weak, p_pull}, 32'hf);
      wait_on(0, 60);
      note("reset_pin");
      put(`RPMC_OFS_INTEN, 32'h10);
      gate_off <= 1'b1;
      repeat (50) @(posedge free_clk);
      chk(mclk, 32'h0);
      chk({cpu_rst, pc_halt, s_ovr}, 32'h0);
      gate_off <= 1'b0;
      @(posedge mclk);
      get(`RPMC_OFS_INTEN, 32'h37f, 32'h10);
      note("standby");
      // Ext0 and timer 0 pend first, then one write enables both in the same cycle
      int_go <= 2'h1;
      req <= 5'h01;
      @(posedge mclk);
      int_go <= 2'h0;
      put(`RPMC_OFS_INTEN, 32'h5);
      wait_on(1, 10);
      chk(irq_vec, `RPMC_VEC_EX0);
      req <= 5'h00;
      note("rank");
      wrap_up();
   end

   // Whole run is under 3000 clocks; the limit leaves a wide margin
   initial begin
      #500000;
      miscompares++;
      wrap_up();
   end
endmodule : rpmc_top_bench
`default_nettype wire
